//--- design/pkls_panel.sv
// Panel feature keys, protection profiles, battery test and loop transfer control.
// Operation
// R01 - Change mode accepts key selections for ten seconds, then expires unchanged.
// R02 - Feature indicators show state whether set locally or remotely.
// R03 - Non-reclosing suppresses recloses but keeps the active curve selection.
// R04 - Supervisory blocking refuses remote commands; status, metering, trip, close stay.
// R05 - Supervisory blocking is turned on only from the keypad via change key.
// R06 - Unblocked cold-load feature replaces the first-operation protection settings.
// R07 - Battery key starts a test; its indicator lights until test completes.
// R08 - Battery test also starts every twelve hours and on external command.
// R09 - Drain until equalized, load, flag check-battery when drop exceeds 2 volts.
// R10 - Fast trips disabled selects the dedicated curve for all trips.
// R11 - Four profiles, three alternates; no alternate lit means normal profile.
// R12 - Change key plus alternate key selects; deselect returns normal; remote too.
// R13 - In sectionalizing mode the second-source inhibit has no effect.
// R14 - A disabled source starts no transfer delay and completes no action.
// R15 - Loop reset from key or links re-arms and clears pending indicator.
// R16 - Phase LEDs lit with voltage; loss turns them off and starts timing.
// R17 - Voltage back before expiry relights LEDs and resets the timing.
// R18 - After expiry LEDs latch off, marking initiator, until loop reset.
// R19 - Loss of voltage is declared 10 percent below the present threshold.
// R20 - Tie mode: no timing with both sources dead; timer reloads on double failure.
// R21 - Inhibited indicator: first source disable (sectionalizing) or both (tie).
// R22 - On supply return tie mode disables both sources; sectionalizing keeps state.
// Assumes keypad pulses last one cycle and voltages and battery readings are synchronous.
//
// The AXI4-Lite register port and the address map were decided locally.
module pkls_panel
  import pkls_pkg::*;
#(
  parameter longint unsigned CHANGE_CYC = CHANGE_WINDOW_CYC,
  parameter longint unsigned BATT_CYC = BATT_PERIOD_CYC
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // Keypad, one-cycle pulses
  input wire logic change_entry_key_i,
  input wire logic [N_FEAT-1:0] feat_key_i,
  input wire logic [2:0] alt_key_i,
  input wire logic batt_key_i,
  input wire logic ls_reset_key_i,
  // Discrete supervisory inputs, one-cycle pulses
  input wire logic ext_batt_req_i,
  input wire logic ext_ls_reset_i,
  // Supply and mode
  input wire logic supply_restored_i,
  input wire logic tie_mode_i,
  // Measurements
  input wire logic [2:0][15:0] src1_v_i,
  input wire logic [2:0][15:0] src2_v_i,
  input wire logic [15:0] batt_mv_i,
  input wire logic batt_equalized_i,
  // Battery load control
  output logic batt_drain_o,
  output logic batt_load_o,
  // Protection steering
  output logic reclose_allowed_o,
  output logic use_fast_dis_curve_o,
  output logic use_cold_load_o,
  output logic gnd_trip_blocked_o,
  output logic [1:0] active_profile_o,
  output logic transfer_act_o,
  // Indicators
  output logic [N_FEAT-1:0] feat_led_o,
  output logic [2:0] alt_led_o,
  output logic batt_led_o,
  output logic check_batt_o,
  output logic transfer_pending_indicator_o,
  output logic transfer_inhibited_indicator_o,
  output logic [2:0] src1_led_o,
  output logic [2:0] src2_led_o,
  output logic sect_led_o,
  output logic tie_led_o,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import pkls_pkg::*;

  logic [N_FEAT-1:0] feat;
  logic [1:0] prof;
  logic change_mode;
  logic [63:0] change_cnt;
  logic [63:0] batt_cnt;
  pkls_bt_e bt_state;
  logic [15:0] equal_mv;
  logic [15:0] vthresh;
  logic [31:0] delay_cyc;
  logic pending;
  logic aw_held, w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_do;
  logic rem_ok;
  logic [31:0] rem_cmd;
  logic [31:0] status;
  logic src1_en, src2_en, inhibited;
  logic rearm;
  logic t1_exp, t2_exp, t1_all, t2_all;
  logic tie_restart;
  logic batt_start;

  // Write channel capture; address and data may arrive in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_do = aw_held && w_held && !s_axi_bvalid;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_do) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr)
          REG_CTRL, REG_VTHRESH, REG_DELAY, REG_PHASE_V: s_axi_bresp <= AXI_OKAY;
          REG_STATUS, REG_BATT: s_axi_bresp <= AXI_OKAY;
          default: s_axi_bresp <= AXI_SLVERR;
        endcase
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Remote commands are refused while supervisory blocking is on
  assign rem_ok = !feat[F_SUP_BLK]; // R04
  assign rem_cmd = (wr_do && aw_addr == REG_CTRL && rem_ok && w_strb[0] && w_strb[1])
                   ? w_data : 32'h0;

  // Settings register writes are refused too while supervisory blocking is on
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      vthresh <= 16'h0000;
      delay_cyc <= 32'h0000_0400;
    end else if (wr_do && rem_ok) begin
      if (aw_addr == REG_VTHRESH) vthresh <= w_data[15:0];
      if (aw_addr == REG_DELAY) delay_cyc <= w_data;
    end
  end

  // Change mode window, restarted by the change key or any feature or alternate key taken inside it
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      change_mode <= 1'b0;
      change_cnt <= 64'h0;
    end else if (change_entry_key_i) begin
      change_mode <= 1'b1;
      change_cnt <= 64'h0;
    end else if (change_mode) begin
      if (|feat_key_i || |alt_key_i) begin
        change_cnt <= 64'h0;
      end else if (change_cnt + 64'h1 >= CHANGE_CYC) begin
        change_mode <= 1'b0; // R01
      end else begin
        change_cnt <= change_cnt + 64'h1;
      end
    end
  end

  // Feature toggles from keypad in change mode or from remote writes
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      feat <= '0;
    end else begin
      for (int f = 0; f < N_FEAT; f++) begin
        if (change_mode && feat_key_i[f]) begin
          feat[f] <= ~feat[f]; // R02 R05
        end else if (rem_cmd[C_TOGGLE] && rem_cmd[f] && f != F_SUP_BLK) begin
          feat[f] <= ~feat[f]; // R02 R05
        end
      end
      if (supply_restored_i && tie_mode_i) begin
        feat[F_SRC1_DIS] <= 1'b1; // R22
        feat[F_SRC2_DIS] <= 1'b1;
      end
    end
  end

  // Profile selection; pressing the lit alternate returns to normal
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prof <= PKLS_PROF_NORMAL;
    end else if (change_mode && |alt_key_i) begin
      for (int a = 0; a < 3; a++) begin
        if (alt_key_i[a]) begin
          prof <= (prof == 2'(a + 1)) ? PKLS_PROF_NORMAL : 2'(a + 1); // R12
        end
      end
    end else if (rem_cmd[C_ALT_SET]) begin
      prof <= rem_cmd[C_ALT_LSB +: 2]; // R12
    end
  end
  always_comb begin
    for (int a = 0; a < 3; a++) begin
      alt_led_o[a] = prof == 2'(a + 1); // R11
    end
  end
  assign active_profile_o = prof; // R11

  // Battery test: periodic, key, or external request
  assign batt_start = batt_key_i || ext_batt_req_i || rem_cmd[C_BATT]
                      || (batt_cnt + 64'h1 >= BATT_CYC); // R07 R08
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      batt_cnt <= 64'h0;
    end else if (batt_cnt + 64'h1 >= BATT_CYC) begin
      batt_cnt <= 64'h0; // R08
    end else begin
      batt_cnt <= batt_cnt + 64'h1;
    end
  end
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bt_state <= PKLS_BT_IDLE;
      equal_mv <= 16'h0000;
      check_batt_o <= 1'b0;
    end else begin
      unique case (bt_state)
        PKLS_BT_IDLE: if (batt_start) bt_state <= PKLS_BT_DRAIN; // R07
        PKLS_BT_DRAIN: begin
          if (batt_equalized_i) begin
            equal_mv <= batt_mv_i; // R09
            bt_state <= PKLS_BT_LOAD;
          end
        end
        PKLS_BT_LOAD: begin
          // Drop measured with load resistor across the terminals
          check_batt_o <= (equal_mv > batt_mv_i)
                          && (equal_mv - batt_mv_i > BATT_DROP_LIMIT_MV); // R09
          bt_state <= PKLS_BT_IDLE;
        end
        default: bt_state <= PKLS_BT_IDLE;
      endcase
    end
  end
  assign batt_drain_o = bt_state == PKLS_BT_DRAIN;
  assign batt_load_o = bt_state == PKLS_BT_LOAD;
  assign batt_led_o = bt_state != PKLS_BT_IDLE; // R07

  // Protection steering
  assign reclose_allowed_o = !feat[F_NON_RECL]; // R03
  assign use_fast_dis_curve_o = feat[F_FAST_DIS]; // R10
  assign use_cold_load_o = !feat[F_COLD_BLK]; // R06
  assign gnd_trip_blocked_o = feat[F_GND_BLK];
  assign feat_led_o = feat; // R02

  // Source enables; second inhibit ignored when sectionalizing
  assign src1_en = !feat[F_SRC1_DIS]; // R14
  assign src2_en = tie_mode_i && !feat[F_SRC2_DIS]; // R13 R14
  assign inhibited = tie_mode_i ? (feat[F_SRC1_DIS] && feat[F_SRC2_DIS])
                                : feat[F_SRC1_DIS]; // R21
  assign transfer_inhibited_indicator_o = inhibited;
  assign rearm = ls_reset_key_i || ext_ls_reset_i || rem_cmd[C_LS_RESET]; // R15
  // Tie mode reloads timing when both sources are dead
  assign tie_restart = tie_mode_i && t1_all && t2_all; // R20

  pkls_src_timer u_src1 (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .phase_v_i(src1_v_i),
    .vthresh_i(vthresh),
    .delay_cyc_i(delay_cyc),
    .enable_i(src1_en),
    .restart_i(tie_restart),
    .rearm_i(rearm),
    .led_o(src1_led_o),
    .any_dead_o(),
    .all_dead_o(t1_all),
    .expired_o(t1_exp)
  );
  pkls_src_timer u_src2 (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .phase_v_i(src2_v_i),
    .vthresh_i(vthresh),
    .delay_cyc_i(delay_cyc),
    .enable_i(src2_en),
    .restart_i(tie_restart),
    .rearm_i(rearm),
    .led_o(src2_led_o),
    .any_dead_o(),
    .all_dead_o(t2_all),
    .expired_o(t2_exp)
  );

  // Pending indicator set on expiry; set wins over a same-cycle reset only while pending is clear
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pending <= 1'b0;
    end else if ((t1_exp && src1_en) || (t2_exp && src2_en)) begin
      pending <= !rearm || pending == 1'b0; // R14
    end else if (rearm) begin
      pending <= 1'b0; // R15
    end
  end
  assign transfer_pending_indicator_o = pending;
  assign transfer_act_o = pending && !inhibited; // R14
  assign sect_led_o = !tie_mode_i;
  assign tie_led_o = tie_mode_i;

  // Status word and read channel
  assign status = {10'h0, src2_led_o, src1_led_o, tie_mode_i, change_mode, inhibited, pending,
                   check_batt_o, batt_led_o, prof, 1'b0, feat};
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= AXI_OKAY;
      case (s_axi_araddr)
        REG_CTRL: s_axi_rdata <= {24'h0, 1'b0, feat};
        REG_STATUS: s_axi_rdata <= status; // R04
        REG_VTHRESH: s_axi_rdata <= {16'h0, vthresh};
        REG_BATT: s_axi_rdata <= {equal_mv, batt_mv_i};
        REG_DELAY: s_axi_rdata <= delay_cyc;
        REG_PHASE_V: s_axi_rdata <= {16'h0, src1_v_i[0]};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= AXI_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks
  property p_sup_local;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      (!feat[F_SUP_BLK] && !(change_mode && feat_key_i[F_SUP_BLK])) |=> !feat[F_SUP_BLK];
  endproperty
  a_sup_local: assert property (p_sup_local) else $error("blocking set remotely"); // R05
  property p_nonrecl;
    @(posedge ref_clk_i) disable iff (!arst_n_i) feat[F_NON_RECL] |-> !reclose_allowed_o;
  endproperty
  a_nonrecl: assert property (p_nonrecl) else $error("reclose while non-reclosing"); // R03
  property p_batt_seq;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      (bt_state == PKLS_BT_IDLE && batt_key_i) |=> batt_led_o && batt_drain_o;
  endproperty
  a_batt_seq: assert property (p_batt_seq) else $error("battery test not started"); // R07
  property p_inhib;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      (!tie_mode_i && feat[F_SRC1_DIS]) |-> transfer_inhibited_indicator_o;
  endproperty
  a_inhib: assert property (p_inhib) else $error("inhibit indicator wrong"); // R21
  property p_rearm;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      (rearm && !t1_exp && !t2_exp) |=> !pending;
  endproperty
  a_rearm: assert property (p_rearm) else $error("pending not cleared"); // R15
  property p_profile;
    @(posedge ref_clk_i) disable iff (!arst_n_i) (alt_led_o == 3'h0) |-> prof == PKLS_PROF_NORMAL;
  endproperty
  a_profile: assert property (p_profile) else $error("profile not normal"); // R11
  property p_tie_power;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      (supply_restored_i && tie_mode_i) |=> feat[F_SRC1_DIS] && feat[F_SRC2_DIS];
  endproperty
  a_tie_power: assert property (p_tie_power) else $error("tie not disabled"); // R22
  property p_sup_rem;
    @(posedge ref_clk_i) disable iff (!arst_n_i) feat[F_SUP_BLK] |-> rem_cmd == 32'h0;
  endproperty
  a_sup_rem: assert property (p_sup_rem) else $error("remote command passed"); // R04
  c_batt: cover property (@(posedge ref_clk_i) bt_state == PKLS_BT_LOAD);
  c_pending: cover property (@(posedge ref_clk_i) pending);
  c_alt: cover property (@(posedge ref_clk_i) prof == PKLS_PROF_ALT3);
endmodule

//--- common/pkls_pkg.sv
// Package for the panel key and loop transfer block: register map, fields, timing.
// Assumes a 125 MHz clock and an AXI4-Lite register bus of 32 bits.
package pkls_pkg;
  // Clock and times
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned CHANGE_WINDOW_S = 10;
  localparam int unsigned BATT_PERIOD_H = 12;
  localparam longint unsigned CHANGE_WINDOW_CYC = longint'(CHANGE_WINDOW_S) * CLK_HZ;
  localparam longint unsigned BATT_PERIOD_CYC = longint'(BATT_PERIOD_H) * 3600 * CLK_HZ;
  // Battery drop limit in millivolts
  localparam logic [15:0] BATT_DROP_LIMIT_MV = 16'h07d0;
  // Loss-of-voltage level is the present threshold less 10 percent
  localparam int unsigned LOSS_PCT = 10;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_VTHRESH = 8'h08;
  localparam logic [7:0] REG_BATT = 8'h0c;
  localparam logic [7:0] REG_DELAY = 8'h10;
  localparam logic [7:0] REG_PHASE_V = 8'h14;
  // Feature bit positions in control and status words
  localparam int unsigned F_GND_BLK = 0;
  localparam int unsigned F_NON_RECL = 1;
  localparam int unsigned F_SUP_BLK = 2;
  localparam int unsigned F_COLD_BLK = 3;
  localparam int unsigned F_FAST_DIS = 4;
  localparam int unsigned F_SRC1_DIS = 5;
  localparam int unsigned F_SRC2_DIS = 6;
  localparam int unsigned N_FEAT = 7;
  // Remote command bits in control word (write one to act)
  localparam int unsigned C_ALT_LSB = 8;
  localparam int unsigned C_ALT_SET = 10;
  localparam int unsigned C_BATT = 11;
  localparam int unsigned C_LS_RESET = 12;
  localparam int unsigned C_TOGGLE = 13;
  // Status-only bit positions
  localparam int unsigned S_ALT_LSB = 8;
  localparam int unsigned S_BATT_RUN = 10;
  localparam int unsigned S_CHECK_BATT = 11;
  localparam int unsigned S_PENDING = 12;
  localparam int unsigned S_INHIBITED = 13;
  localparam int unsigned S_CHANGE = 14;
  localparam int unsigned S_TIE = 15;
  localparam int unsigned S_LEDS_LSB = 16;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
  // Profile selection codes
  typedef enum logic [1:0] {
    PKLS_PROF_NORMAL = 2'b00,
    PKLS_PROF_ALT1 = 2'b01,
    PKLS_PROF_ALT2 = 2'b10,
    PKLS_PROF_ALT3 = 2'b11
  } pkls_prof_e;
  // Battery test sequence
  typedef enum logic [1:0] {
    PKLS_BT_IDLE = 2'b00,
    PKLS_BT_DRAIN = 2'b01,
    PKLS_BT_LOAD = 2'b10
  } pkls_bt_e;
endpackage

//--- design/pkls_src_timer.sv
// One source's loss-of-voltage detector, transfer delay timer and latched LEDs.
// Assumes phase voltages arrive as synchronous sampled words in the ref_clk_i domain.
module pkls_src_timer
  import pkls_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // Voltage and settings
  input wire logic [2:0][15:0] phase_v_i,
  input wire logic [15:0] vthresh_i,
  input wire logic [31:0] delay_cyc_i,
  // Control
  input wire logic enable_i,
  input wire logic restart_i,
  input wire logic rearm_i,
  // Results
  output logic [2:0] led_o,
  output logic any_dead_o,
  output logic all_dead_o,
  output logic expired_o
);
  logic [2:0] alive;
  logic [2:0] latched;
  logic [31:0] count;
  logic timing;
  logic [15:0] loss_level;

  // Loss level sits 10 percent below the present threshold
  assign loss_level = 16'((32'(vthresh_i) * (100 - LOSS_PCT)) / 100); // R19
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      alive[p] = phase_v_i[p] >= loss_level;
    end
  end
  assign any_dead_o = ~&alive;
  assign all_dead_o = ~|alive;

  // Timer runs while a phase is down; recovery or restart reloads it
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count <= 32'h0;
      timing <= 1'b0;
      expired_o <= 1'b0;
    end else if (rearm_i) begin
      count <= 32'h0; // R15
      timing <= 1'b0;
      expired_o <= 1'b0;
    end else if (expired_o) begin
      timing <= 1'b0;
    end else if (!enable_i || !any_dead_o || restart_i) begin
      count <= 32'h0; // R14 R17 R20
      timing <= enable_i && any_dead_o;
    end else if (count + 32'h1 >= delay_cyc_i) begin
      expired_o <= 1'b1;
      timing <= 1'b0;
    end else begin
      count <= count + 32'h1;
      timing <= 1'b1;
    end
  end

  // Latched LEDs hold the phases that were down at expiry
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      latched <= 3'h0;
    end else if (rearm_i) begin
      latched <= 3'h0;
    end else if (!expired_o && count + 32'h1 >= delay_cyc_i && enable_i && any_dead_o
                 && !restart_i) begin
      latched <= ~alive; // R18
    end
  end
  // LEDs follow live voltage until expiry, then dead phases stay dark
  assign led_o = expired_o ? (alive & ~latched) : alive; // R16 R18
endmodule

//--- tb/pkls_keypad_model.sv
// Keypad model: the bench names a key by code and the model pulses it for one cycle.
// Assumes press_i is raised for one cycle just after a clock edge.
module pkls_keypad_model (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // Code: 0 change, 1..7 feature, 8..10 alternate, 11 battery, 12 loop reset
  input wire logic press_i,
  input wire logic [3:0] code_i,
  // Key pulses
  output logic chg_o,
  output logic [6:0] feat_o,
  output logic [2:0] alt_o,
  output logic batt_o,
  output logic rst_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] hot;
  // One key at a time; gated by reset so a pulse is never unknown
  always_ff @(posedge ref_clk_i) begin
    hot <= press_i ? 16'h0001 << code_i : 16'h0000;
  end
  assign chg_o = hot[0] & arst_n_i;
  assign feat_o = hot[7:1] & {7{arst_n_i}};
  assign alt_o = hot[10:8] & {3{arst_n_i}};
  assign batt_o = hot[11] & arst_n_i;
  assign rst_o = hot[12] & arst_n_i;
endmodule

//--- tb/pkls_panel_test.sv
// Bench for the panel keys and loop transfer block.
// Assumes shortened change window and battery period at the instance.
module pkls_panel_test;
  timeunit 1ns;
  timeprecision 1ps;
  import pkls_pkg::*;
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic press = 1'b0;
  logic [3:0] code = 4'h0;
  logic change_entry_key_i, batt_key_i, ls_reset_key_i;
  logic [6:0] feat_key_i;
  logic [2:0] alt_key_i;
  logic ext_batt_req_i = 1'b0;
  logic ext_ls_reset_i = 1'b0;
  logic supply_restored_i = 1'b0;
  logic tie_mode_i = 1'b0;
  logic batt_equalized_i = 1'b0;
  logic [15:0] batt_mv_i = 16'h0000;
  logic [2:0][15:0] src1_v_i = {3{16'h0400}};
  logic [2:0][15:0] src2_v_i = {3{16'h0400}};
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  // Panel outputs
  logic batt_drain_o, batt_load_o, reclose_allowed_o, use_fast_dis_curve_o, use_cold_load_o;
  logic gnd_trip_blocked_o, transfer_act_o, batt_led_o, check_batt_o, sect_led_o, tie_led_o;
  logic transfer_pending_indicator_o, transfer_inhibited_indicator_o;
  logic [1:0] active_profile_o, s_axi_bresp, s_axi_rresp, r;
  logic [6:0] feat_led_o;
  logic [2:0] alt_led_o, src1_led_o, src2_led_o;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_rdata, d;
  int bad_count = 0;
  int compares = 0;
  pkls_panel #(.CHANGE_CYC(20), .BATT_CYC(200)) dut_u (.*);
  pkls_keypad_model key_u (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .press_i(press),
    .code_i(code), .chg_o(change_entry_key_i), .feat_o(feat_key_i), .alt_o(alt_key_i),
    .batt_o(batt_key_i), .rst_o(ls_reset_key_i));
  initial begin
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bus tasks: each is entered just after a rising edge and returns just after one
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    // Ready stays up between calls; each write drives it high again at its start
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    e = s_axi_rresp;
  endtask
  task automatic key(input logic [3:0] c);
    press <= 1'b1;
    code <= c;
    @(posedge ref_clk_i);
    press <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
  endtask
  task automatic t_change();
    key(4'h1);
    chk(32'(feat_led_o[0]), 32'h0);
    key(4'h0);
    key(4'h1);
    chk(32'(gnd_trip_blocked_o), 32'h1);
    repeat (25) @(posedge ref_clk_i);
    key(4'h1);
    chk(32'(feat_led_o[0]), 32'h1);
  endtask
  task automatic t_remote();
    chk(32'(use_cold_load_o), 32'h1);
    wr(REG_CTRL, 32'h0000_201a);
    chk(32'(feat_led_o), 32'h1b);
    chk(32'(reclose_allowed_o), 32'h0);
    chk(32'(active_profile_o), 32'h0);
    chk(32'(use_cold_load_o), 32'h0);
    chk(32'(use_fast_dis_curve_o), 32'h1);
  endtask
  task automatic t_supblk();
    wr(REG_CTRL, 32'h0000_2004);
    chk(32'(feat_led_o[2]), 32'h0);
    key(4'h0);
    key(4'h3);
    chk(32'(feat_led_o[2]), 32'h1);
    wr(REG_CTRL, 32'h0000_2001);
    wr(REG_DELAY, 32'h0000_0020);
    rd(REG_DELAY, d, r);
    chk(d, 32'h0000_0400);
    chk(32'(feat_led_o[0]), 32'h1);
    rd(REG_STATUS, d, r);
    chk(32'({d[2], r}), 32'({1'b1, AXI_OKAY}));
    rd(8'h40, d, r);
    chk(32'(r), 32'(AXI_SLVERR));
    wr(8'h40, 32'h0);
    chk(32'(s_axi_bresp), 32'(AXI_SLVERR));
    key(4'h0);
    key(4'h3);
  endtask
  task automatic t_profile();
    for (int i = 0; i < 3; i++) begin
      key(4'h0);
      key(4'(8 + i));
      chk(32'(active_profile_o), 32'(i + 1));
      chk(32'(alt_led_o), 32'(1 << i));
    end
    key(4'h0);
    key(4'ha);
    chk(32'({alt_led_o, active_profile_o}), 32'h0);
    wr(REG_CTRL, 32'h0000_0600);
    chk(32'(active_profile_o), 32'h2);
  endtask
  task automatic t_loop();
    wr(REG_VTHRESH, 32'h0000_03e8);
    wr(REG_DELAY, 32'h0000_0010);
    // 928 sits above the 900 loss level, so it must count as present
    src1_v_i[0] <= 16'h03a0;
    repeat (30) @(posedge ref_clk_i);
    chk(32'({transfer_pending_indicator_o, src1_led_o}), 32'h7);
    chk(32'(src2_led_o), 32'h7);
    // Two short dips that together outlast the delay: no expiry if timing resets
    for (int i = 0; i < 2; i++) begin
      src1_v_i[0] <= 16'h0380;
      repeat (10) @(posedge ref_clk_i);
      chk(32'(src1_led_o), 32'h6);
      src1_v_i[0] <= 16'h0400;
      repeat (2) @(posedge ref_clk_i);
      chk(32'({transfer_pending_indicator_o, src1_led_o}), 32'h7);
    end
    for (int i = 0; i < 2; i++) begin
      src1_v_i[0] <= 16'h0380;
      repeat (24) @(posedge ref_clk_i);
      src1_v_i[0] <= 16'h0400;
      repeat (3) @(posedge ref_clk_i);
      chk(32'({transfer_pending_indicator_o, src1_led_o}), 32'he);
      chk(32'({transfer_act_o, sect_led_o, tie_led_o}), 32'h6);
      if (i == 0) key(4'hc);
      else wr(REG_CTRL, 32'h0000_1000);
      chk(32'({transfer_pending_indicator_o, src1_led_o}), 32'h7);
    end
    key(4'h0);
    key(4'h7);
    chk(32'(transfer_inhibited_indicator_o), 32'h0);
    key(4'h6);
    chk(32'(transfer_inhibited_indicator_o), 32'h1);
    src1_v_i[0] <= 16'h0380;
    repeat (24) @(posedge ref_clk_i);
    chk(32'(transfer_pending_indicator_o), 32'h0);
    src1_v_i[0] <= 16'h0400;
  endtask
  task automatic t_batt();
    int n;
    n = 0;
    batt_mv_i <= 16'h5dc0;
    key(4'hb);
    chk(32'({batt_led_o, batt_drain_o}), 32'h3);
    batt_equalized_i <= 1'b1;
    // Equalized value is taken on this edge; the loaded value drops by 3000 mV
    @(posedge ref_clk_i);
    batt_mv_i <= 16'h5208;
    batt_equalized_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    chk(32'(check_batt_o), 32'h1);
    chk(32'(batt_led_o), 32'h0);
    while (!batt_led_o && n < 210) begin
      @(posedge ref_clk_i);
      n++;
    end
    chk(32'(batt_led_o), 32'h1);
  endtask
  task automatic tally_and_finish();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    t_change();
    t_remote();
    t_supblk();
    t_profile();
    t_loop();
    t_batt();
    tally_and_finish();
  end
  // Whole run needs about four hundred cycles
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    bad_count++;
    tally_and_finish();
  end
endmodule
